/* File: include/sxm_pkg.sv */
// constants, types and helpers shared by the serial expansion master
package sxm_pkg;
	// transfer word width and FIFO depth defaults
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 8;

	// system clock rate, for reference by timing constants
	localparam int SYS_CLK_HZ = 50_000_000;

	// peripheral number as selected by software
	typedef logic [2:0] sxm_dev_t;
	localparam sxm_dev_t DEV_PERIPH_A  = 3'h0;
	localparam sxm_dev_t DEV_PERIPH_B  = 3'h1;
	localparam sxm_dev_t DEV_CONVERTER = 3'h5;

	// serial clock division ratio select
	typedef logic [1:0] sxm_div_t;
	localparam sxm_div_t DIV_BY_4  = 2'h0;
	localparam sxm_div_t DIV_BY_8  = 2'h1;
	localparam sxm_div_t DIV_BY_16 = 2'h2;
	localparam sxm_div_t DIV_BY_32 = 2'h3;

	// half serial clock period in system clocks for each ratio
	typedef logic [4:0] sxm_half_t;
	localparam sxm_half_t HALF_DIV_4  = 5'h02;
	localparam sxm_half_t HALF_DIV_8  = 5'h04;
	localparam sxm_half_t HALF_DIV_16 = 5'h08;
	localparam sxm_half_t HALF_DIV_32 = 5'h10;
	localparam sxm_half_t HALF_ONE    = 5'h01;
	localparam sxm_half_t HALF_ZERO   = 5'h00;

	// frame sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_SHIFT,
		ST_GAP
	} sxm_state_t;

	// half period length for a ratio select
	function automatic sxm_half_t sxm_half_count(input sxm_div_t sel);
		case (sel)
			DIV_BY_4:  sxm_half_count = HALF_DIV_4;
			DIV_BY_8:  sxm_half_count = HALF_DIV_8;
			DIV_BY_16: sxm_half_count = HALF_DIV_16;
			default:   sxm_half_count = HALF_DIV_32;
		endcase
	endfunction : sxm_half_count
endpackage : sxm_pkg

/* File: include/sxm_stream_if.sv */
// valid/ready word stream between the master and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface sxm_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	// producer side
	modport src (
		output valid,
		output data,
		input  ready
	);

	// consumer side
	modport snk (
		input  valid,
		input  data,
		output ready
	);
endinterface : sxm_stream_if
`default_nettype wire

/* File: rtl/sxm_fifo.sv */
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sxm_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic sys_clk, // system clock
	input  wire logic resetn,  // async reset, active low
	sxm_stream_if.snk wr,      // fill side
	sxm_stream_if.src rd       // drain side
);
	import sxm_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] next_mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr;
	logic [AW-1:0] rd_ptr, next_rd_ptr;
	logic [AW:0]   count, next_count;
	logic          do_wr, do_rd;

	// honest flags straight from the occupancy count
	assign wr.ready = (count != (AW+1)'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data  = mem[rd_ptr];
	assign do_wr    = wr.valid && wr.ready;
	assign do_rd    = rd.valid && rd.ready;

	// pointer and storage next values
	always_comb begin
		next_mem    = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (do_wr) begin
			next_mem[wr_ptr] = wr.data;
			next_wr_ptr      = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
		end
		if (do_rd) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
		end
		if (do_wr && !do_rd) begin
			next_count = count + 1'b1;
		end else if (do_rd && !do_wr) begin
			next_count = count - 1'b1;
		end
	end

	// storage needs no reset, pointers do
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge sys_clk) begin
		mem <= next_mem;
	end
endmodule : sxm_fifo
`default_nettype wire

/* File: rtl/sxm_master.sv */
// serial expansion bus master: clock divider, mode control, selects, shifter
// Summary of operation
// - The master alone generates the serial clock; no port lets anyone else drive it.
// - Every frame starts from the master when a queued word is present, never from a peripheral.
// - Clock idle level and sampling phase are separate controls, covering all four modes.
// - The serial clock is the system clock divided by 4, 8, 16 or 32 per software select.
// - Two separate active-low selects reach the two external peripherals.
// - Selecting peripheral number 5 asserts the converter read strobe for that frame.
`timescale 1ns/1ps
`default_nettype none
module sxm_master #(
	parameter int DATA_W     = sxm_pkg::DATA_W,
	parameter int FIFO_DEPTH = sxm_pkg::FIFO_DEPTH
) (
	input  wire logic              sys_clk,               // system clock, 50 MHz
	input  wire logic              resetn,                // async reset, active low
	input  wire logic              cpol,                  // clock idle level
	input  wire logic              cpha,                  // 1: sample on trailing edge
	input  wire sxm_pkg::sxm_div_t clk_div_sel,           // division ratio select
	input  wire sxm_pkg::sxm_dev_t dev_sel,               // peripheral number
	input  wire logic              tx_valid,              // word offered
	output logic                   tx_ready,              // FIFO has room
	input  wire logic [DATA_W-1:0] tx_data,               // word to send, msb first
	output logic [DATA_W-1:0]      rx_data,               // last word received
	output logic                   rx_valid,              // one-cycle pulse, rx_data new
	output logic                   busy,                  // frame in progress
	output logic                   sclk,                  // serial clock pin
	output logic                   mosi,                  // master output data pin
	input  wire logic              miso,                  // master input data pin
	output logic                   peripheral_select_a_n, // external select a
	output logic                   peripheral_select_b_n, // external select b
	output logic                   converter_strobe_n     // converter read strobe
);
	import sxm_pkg::*;

	localparam int EW = $clog2(2*DATA_W);

	sxm_stream_if #(.W(DATA_W)) wr_if ();
	sxm_stream_if #(.W(DATA_W)) rd_if ();

	sxm_state_t       state, next_state;
	sxm_half_t        half_cnt, next_half_cnt;
	logic [EW-1:0]    edge_cnt, next_edge_cnt;
	logic [DATA_W-1:0] tx_sh, next_tx_sh;
	logic [DATA_W-1:0] rx_sh, next_rx_sh;
	logic [DATA_W-1:0] next_rx_data;
	logic             next_rx_valid;
	logic             next_sclk, next_mosi;
	logic             next_sel_a_n, next_sel_b_n, next_conv_n;
	logic             f_cpha, next_f_cpha;
	logic             f_cpol, next_f_cpol;
	sxm_div_t         f_div, next_f_div;
	logic             miso_meta, miso_s;
	logic             leading, shift_edge;

	// queue in front of the shifter; tx_ready is the back-pressure
	assign wr_if.valid = tx_valid;
	assign wr_if.data  = tx_data;
	assign tx_ready    = wr_if.ready;

	sxm_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) i_sxm_fifo (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.wr      (wr_if.snk),
		.rd      (rd_if.src)
	);

	// pin input crosses into sys_clk through two flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			miso_meta <= 1'b0;
			miso_s    <= 1'b0;
		end else begin
			miso_meta <= miso;
			miso_s    <= miso_meta;
		end
	end

	assign busy = (state != ST_IDLE);

	// even edge count marks a leading edge of the serial clock
	assign leading    = (edge_cnt[0] == 1'b0);
	assign shift_edge = leading ? f_cpha : !f_cpha;

	// frame sequencer next values
	always_comb begin
		next_state    = state;
		next_half_cnt = half_cnt;
		next_edge_cnt = edge_cnt;
		next_tx_sh    = tx_sh;
		next_rx_sh    = rx_sh;
		next_rx_data  = rx_data;
		next_rx_valid = 1'b0;
		next_sclk     = sclk;
		next_mosi     = mosi;
		next_sel_a_n  = peripheral_select_a_n;
		next_sel_b_n  = peripheral_select_b_n;
		next_conv_n   = converter_strobe_n;
		next_f_cpha   = f_cpha;
		next_f_cpol   = f_cpol;
		next_f_div    = f_div;
		rd_if.ready   = 1'b0;
		case (state)
			ST_IDLE: begin
				next_sclk = cpol;
				if (rd_if.valid) begin
					rd_if.ready   = 1'b1;
					next_f_cpha   = cpha;
					next_f_cpol   = cpol;
					next_f_div    = clk_div_sel;
					next_half_cnt = sxm_half_count(clk_div_sel) - HALF_ONE;
					next_edge_cnt = '0;
					next_rx_sh    = '0;
					// first bit is on the line before any edge
					next_mosi     = rd_if.data[DATA_W-1];
					next_tx_sh    = cpha ? rd_if.data : {rd_if.data[DATA_W-2:0], 1'b0};
					next_sel_a_n  = (dev_sel != DEV_PERIPH_A);
					next_sel_b_n  = (dev_sel != DEV_PERIPH_B);
					next_conv_n   = (dev_sel != DEV_CONVERTER);
					next_state    = ST_LEAD;
				end
			end
			ST_LEAD: begin
				// select settles two half periods before the first edge
				if (half_cnt == HALF_ZERO) begin
					next_half_cnt = sxm_half_count(f_div) - HALF_ONE;
					next_state    = ST_SHIFT;
				end else begin
					next_half_cnt = half_cnt - HALF_ONE;
				end
			end
			ST_SHIFT: begin
				if (half_cnt == HALF_ZERO) begin
					next_sclk     = !sclk;
					next_half_cnt = sxm_half_count(f_div) - HALF_ONE;
					next_edge_cnt = edge_cnt + 1'b1;
					if (shift_edge) begin
						next_mosi  = tx_sh[DATA_W-1];
						next_tx_sh = {tx_sh[DATA_W-2:0], 1'b0};
					end else begin
						next_rx_sh = {rx_sh[DATA_W-2:0], miso_s};
					end
					if (edge_cnt == EW'(2*DATA_W-1)) begin
						next_rx_data  = next_rx_sh;
						next_rx_valid = 1'b1;
						next_sel_a_n  = 1'b1;
						next_sel_b_n  = 1'b1;
						next_conv_n   = 1'b1;
						next_state    = ST_GAP;
					end
				end else begin
					next_half_cnt = half_cnt - HALF_ONE;
				end
			end
			ST_GAP: begin
				// selects stay high a half period so frames are seen apart
				next_sclk = f_cpol;
				if (half_cnt == HALF_ZERO) begin
					next_state = ST_IDLE;
				end else begin
					next_half_cnt = half_cnt - HALF_ONE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state                 <= ST_IDLE;
			half_cnt              <= HALF_ZERO;
			edge_cnt              <= '0;
			tx_sh                 <= '0;
			rx_sh                 <= '0;
			rx_data               <= '0;
			rx_valid              <= 1'b0;
			sclk                  <= 1'b0;
			mosi                  <= 1'b0;
			peripheral_select_a_n <= 1'b1;
			peripheral_select_b_n <= 1'b1;
			converter_strobe_n    <= 1'b1;
			f_cpha                <= 1'b0;
			f_cpol                <= 1'b0;
			f_div                 <= DIV_BY_4;
		end else begin
			state                 <= next_state;
			half_cnt              <= next_half_cnt;
			edge_cnt              <= next_edge_cnt;
			tx_sh                 <= next_tx_sh;
			rx_sh                 <= next_rx_sh;
			rx_data               <= next_rx_data;
			rx_valid              <= next_rx_valid;
			sclk                  <= next_sclk;
			mosi                  <= next_mosi;
			peripheral_select_a_n <= next_sel_a_n;
			peripheral_select_b_n <= next_sel_b_n;
			converter_strobe_n    <= next_conv_n;
			f_cpha                <= next_f_cpha;
			f_cpol                <= next_f_cpol;
			f_div                 <= next_f_div;
		end
	end
endmodule : sxm_master
`default_nettype wire

/* File: sim/sxm_master_assertions.sv */
// port checks for the serial expansion master
`timescale 1ns/1ps
`default_nettype none
module sxm_master_chk (
	input wire logic              sys_clk,               // clock
	input wire logic              resetn,                // reset, low
	input wire logic              cpol,                  // idle level
	input wire sxm_pkg::sxm_div_t clk_div_sel,           // ratio
	input wire sxm_pkg::sxm_dev_t dev_sel,               // target
	input wire logic              rx_valid,              // word back
	input wire logic              busy,                  // in frame
	input wire logic              sclk,                  // serial clock
	input wire logic              peripheral_select_a_n, // select a
	input wire logic              peripheral_select_b_n, // select b
	input wire logic              converter_strobe_n     // strobe
);
	import sxm_pkg::*;
	logic       sclk_q;
	logic       busy_q;
	logic       all_hi;
	logic [4:0] half;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic       tog_seen;
	logic       next_tog;
	// cycles since the last clock or busy change; ratio held idle-only
	always_comb begin
		half     = 5'h02 << clk_div_sel;
		all_hi   = peripheral_select_a_n & peripheral_select_b_n & converter_strobe_n;
		next_cnt = (sclk != sclk_q || busy != busy_q) ? 5'h00 : cnt + 5'h01;
		// first clock edge of a frame follows the lead, later ones a half period
		next_tog = busy && busy_q && (tog_seen || sclk != sclk_q);
	end
	// register the helper state
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
			busy_q <= 1'b0;
			cnt    <= 5'h00;
			tog_seen <= 1'b0;
		end else begin
			sclk_q <= sclk;
			busy_q <= busy;
			cnt    <= next_cnt;
			tog_seen <= next_tog;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// frame opening and closing steps
	sequence s_start;
		busy && !busy_q;
	endsequence
	sequence s_close;
		rx_valid ##1 busy;
	endsequence
	a_select_a: assert property (
		s_start |-> peripheral_select_a_n == (dev_sel != DEV_PERIPH_A))
		else $error("select a wrong at frame start");
	a_select_b: assert property (
		s_start |-> peripheral_select_b_n == (dev_sel != DEV_PERIPH_B))
		else $error("select b wrong at frame start");
	a_strobe_conv: assert property (
		s_start |-> converter_strobe_n == (dev_sel != DEV_CONVERTER))
		else $error("converter strobe wrong at frame start");
	a_one_select: assert property (
		$countones({peripheral_select_a_n, peripheral_select_b_n, converter_strobe_n}) >= 2)
		else $error("more than one select low");
	a_idle_high: assert property (!busy |-> all_hi)
		else $error("select low while idle");
	a_release_valid: assert property ($rose(all_hi) |-> s_close)
		else $error("select released without word");
	a_sclk_idle: assert property (
		!busy && !busy_q && $past(resetn) && $stable(cpol) |-> sclk == cpol)
		else $error("serial clock not at idle level");
	a_half_period: assert property (
		sclk != sclk_q && busy && busy_q && tog_seen |-> cnt == half - 5'h01)
		else $error("serial clock half period wrong");
	// select leads the first clock edge by two half periods
	a_lead_time: assert property (
		sclk != sclk_q && busy && busy_q && !tog_seen |-> cnt == {half, 1'b0} - 6'h01)
		else $error("serial clock lead time wrong");
endmodule : sxm_master_chk
`default_nettype wire

/* File: sim/sxm_slave_model.sv */
// serial peripheral model: echoes the previous word, msb first
`timescale 1ns/1ps
`default_nettype none
module sxm_slave_model #(
	parameter logic [7:0] INIT = 8'hA5
) (
	input  wire logic sclk,  // serial clock
	input  wire logic mosi,  // data in
	input  wire logic cpol,  // idle level
	input  wire logic cpha,  // phase
	input  wire logic sel_n, // any select low
	output wire logic miso   // data out
);
	logic [7:0] sr   = INIT;
	logic       cap  = 1'b0;
	logic       pend = 1'b0;
	logic       drv  = 1'b0;
	wire logic  sel_d;
	// delayed select keeps the final clock edge inside the frame when both move together
	assign #1 sel_d = sel_n;
	always @(sel_n or sr) begin
		drv = sel_n ? ~drv : sr[7]; // released line shows the inverse, not a stale bit
	end
	assign miso = drv;
	// sample on one edge, shift on the other
	always @(sclk) begin
		if (!sel_d && ((sclk != cpol) ^ cpha)) begin
			cap  = mosi;
			pend = 1'b1;
		end else if (!sel_d && pend) begin
			sr   = {sr[6:0], cap};
			pend = 1'b0;
		end
	end
	// phase one leaves the last bit until release
	always @(posedge sel_d) begin
		if (pend) begin
			sr   = {sr[6:0], cap};
			pend = 1'b0;
		end
	end
endmodule : sxm_slave_model
`default_nettype wire

/* File: sim/tb_serial_expansion_master.sv */
// self-checking bench for the serial expansion master
`timescale 1ns/1ps
`default_nettype none
module tb_serial_expansion_master;
	import sxm_pkg::*;
	logic       sys_clk, resetn, cpol, cpha, tx_valid, tx_ready, rx_valid, busy, sclk;
	logic       mosi, miso, peripheral_select_a_n, peripheral_select_b_n, converter_strobe_n;
	sxm_div_t   clk_div_sel;
	sxm_dev_t   dev_sel;
	logic [7:0] tx_data, rx_data, prev, sels;
	logic [8:0] exp_q[$];
	logic [8:0] mon_e;
	int         err_count, tests_run, cycles, seed;
	sxm_dev_t   devs[4] = '{DEV_PERIPH_A, DEV_PERIPH_B, DEV_CONVERTER, 3'h3};
	assign sels = {5'h00, peripheral_select_a_n, peripheral_select_b_n, converter_strobe_n};
	sxm_master i_sxm_master (
		.sys_clk, .resetn, .cpol, .cpha, .clk_div_sel, .dev_sel, .tx_valid, .tx_ready,
		.tx_data, .rx_data, .rx_valid, .busy, .sclk, .mosi, .miso,
		.peripheral_select_a_n, .peripheral_select_b_n, .converter_strobe_n
	);
	sxm_slave_model i_sxm_slave_model (
		.sclk, .mosi, .cpol, .cpha, .miso,
		.sel_n(peripheral_select_a_n & peripheral_select_b_n & converter_strobe_n)
	);
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic final_report;
		if (err_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	// offer a word until taken; reply is the last word a selected peer saw
	task automatic send(input logic [7:0] d);
		int k;
		k = 0;
		@(negedge sys_clk);
		tx_valid = 1'b1;
		tx_data  = d;
		while (tx_ready !== 1'b1 && k < 2000) begin
			@(negedge sys_clk);
			k++;
		end
		@(posedge sys_clk);
		if (dev_sel inside {DEV_PERIPH_A, DEV_PERIPH_B, DEV_CONVERTER}) begin
			exp_q.push_back({clk_div_sel != DIV_BY_4, prev}); // fastest ratio too tight for miso
			prev = d;
		end else begin
			exp_q.push_back(9'h000);
		end
	endtask : send
	// idle long enough that no queued word can remain
	task automatic wait_idle;
		int k, t;
		k = 0;
		t = 0;
		while (k < 40 && t < 9000) begin
			@(negedge sys_clk);
			k = (busy === 1'b0) ? k + 1 : 0;
			t++;
		end
	endtask : wait_idle
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	// oldest note against each returned word
	always @(negedge sys_clk) begin
		if (rx_valid === 1'b1 && exp_q.size() == 0) begin
			chk("rx_extra", 8'h00, 8'h01);
		end else if (rx_valid === 1'b1) begin
			mon_e = exp_q.pop_front();
			if (mon_e[8]) begin
				chk("rx_data", mon_e[7:0], rx_data);
			end
		end
	end
	// main sequence
	initial begin
		seed        = 32'h40367219;
		resetn      = 1'b0;
		{cpol, cpha, tx_valid} = 3'h0;
		clk_div_sel = DIV_BY_4;
		dev_sel     = DEV_PERIPH_A;
		tx_data     = 8'h00;
		prev        = 8'hA5;
		repeat (20) @(negedge sys_clk);
		chk("reset_sel", 8'h07, sels);
		chk("reset_out", 8'h01, {4'h0, busy, rx_valid, mosi, tx_ready});
		resetn = 1'b1;
		for (int m = 0; m < 16; m++) begin
			{clk_div_sel, cpha, cpol} = m[3:0];
			dev_sel = devs[(m + m / 4) % 4];
			repeat (3) @(negedge sys_clk);
			send(8'($random(seed)));
			@(negedge sys_clk);
			tx_valid = 1'b0;
			wait_idle();
		end
		// fill until refused, hold the refused word, then drain
		clk_div_sel = DIV_BY_8;
		dev_sel     = DEV_PERIPH_B;
		repeat (FIFO_DEPTH + 1) send(8'($random(seed)));
		@(negedge sys_clk);
		chk("tx_ready", 8'h00, {7'h00, tx_ready});
		repeat (20) @(negedge sys_clk);
		tx_valid = 1'b0;
		wait_idle();
		chk("pending", 8'h00, 8'(exp_q.size()));
		// strobe mid frame, then reset cuts it
		dev_sel  = DEV_CONVERTER;
		tx_valid = 1'b1;
		@(negedge sys_clk);
		tx_valid = 1'b0;
		repeat (30) @(negedge sys_clk);
		chk("strobe", 8'h06, sels);
		resetn = 1'b0;
		#1;
		chk("mid_reset", 8'h07, {4'h0, sclk, sels[2:0]});
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (40) @(negedge sys_clk);
		chk("idle_sel", 8'h07, sels);
		final_report();
	end
endmodule : tb_serial_expansion_master
bind sxm_master sxm_master_chk i_sxm_master_chk (
	.sys_clk, .resetn, .cpol, .clk_div_sel, .dev_sel, .rx_valid, .busy, .sclk,
	.peripheral_select_a_n, .peripheral_select_b_n, .converter_strobe_n
);
`default_nettype wire
